/* File: src/serdes_lane_link_status.sv */
// Per-lane link status bytes with error counters and threshold flags.
// Assumes lane inputs and the read port share CLK_SYS with this block.
`timescale 1ns/1ps
`default_nettype none
`include "lane_flags_defines.svh"
module serdes_lane_link_status #(
  parameter int NUM_LANES = 3
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [NUM_LANES-1:0] BAD_DISPARITY_EVT,
  input wire logic [NUM_LANES-1:0] NOT_IN_TABLE_EVT,
  input wire logic [NUM_LANES-1:0] UNEXPECTED_CONTROL_EVT,
  input wire logic COUNT_CLEAR,
  input wire logic [7:0] ERROR_LIMIT,
  input wire logic [NUM_LANES-1:0] DESKEW_OK,
  input wire logic [NUM_LANES-1:0] LANE_ALIGN_OK,
  input wire logic [NUM_LANES-1:0] CONFIG_SUM_OK,
  input wire logic [NUM_LANES-1:0] FRAME_ALIGN_OK,
  input wire logic [NUM_LANES-1:0] CODE_GROUP_LOCK,
  input wire logic SKIP_ALIGNMENT_SEQUENCE,
  input wire logic RD_EN,
  input wire logic [11:0] RD_ADDR,
  output logic [7:0] RD_DATA,
  output logic RD_VALID
);

  // ***********************************************************
  // Parameter check.
  // ***********************************************************
  if (NUM_LANES < 1 || NUM_LANES > 16) begin : g_bad_lanes
    $error("NUM_LANES must lie between 1 and 16.");
  end

  if (`LANE0_FLAGS_ADDR + NUM_LANES > 4096) begin : g_bad_span
    $error("Lane bytes must fit in the register address space.");
  end

  // ***********************************************************
  // Storage and next values.
  // ***********************************************************
  lane_flags_pkg::flag_byte_type flags_r [NUM_LANES];
  lane_flags_pkg::flag_byte_type flags_nxt [NUM_LANES];
  lane_flags_pkg::error_count_type disp_cnt_r [NUM_LANES];
  lane_flags_pkg::error_count_type disp_cnt_nxt [NUM_LANES];
  lane_flags_pkg::error_count_type nit_cnt_r [NUM_LANES];
  lane_flags_pkg::error_count_type nit_cnt_nxt [NUM_LANES];
  lane_flags_pkg::error_count_type ctrl_cnt_r [NUM_LANES];
  lane_flags_pkg::error_count_type ctrl_cnt_nxt [NUM_LANES];
  logic [NUM_LANES-1:0] disp_full;
  logic [NUM_LANES-1:0] nit_full;
  logic [NUM_LANES-1:0] ctrl_full;
  logic align_valid;
  lane_flags_pkg::reg_addr_type rd_offset;
  logic rd_hit;
  logic [7:0] rd_data_nxt;

  // ***********************************************************
  // Skip-alignment qualifier.
  // ***********************************************************
  // Skip voids alignment bits.
  assign align_valid = !SKIP_ALIGNMENT_SEQUENCE;

  // ***********************************************************
  // Per-lane counters and status bytes.
  // ***********************************************************
  for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane
    // ***********************************************************
    // Saturation detect.
    // ***********************************************************
    // A full counter holds so that it never wraps back below the limit.
    assign disp_full[i] = (disp_cnt_r[i] == `COUNT_MAX);
    assign nit_full[i] = (nit_cnt_r[i] == `COUNT_MAX);
    assign ctrl_full[i] = (ctrl_cnt_r[i] == `COUNT_MAX);

    // ***********************************************************
    // Disparity error counter.
    // ***********************************************************
    // Disparity error count.
    always_comb begin
      disp_cnt_nxt[i] = disp_cnt_r[i];
      if (COUNT_CLEAR) begin
        disp_cnt_nxt[i] = `COUNT_RESET;
      end else if (BAD_DISPARITY_EVT[i] && !disp_full[i]) begin
        disp_cnt_nxt[i] = disp_cnt_r[i] + 8'h01;
      end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
        disp_cnt_r[i] <= `COUNT_RESET;
      end else if (CE) begin
        disp_cnt_r[i] <= disp_cnt_nxt[i];
      end
    end

    // ***********************************************************
    // Not-in-table error counter.
    // ***********************************************************
    // Not-in-table error count.
    always_comb begin
      nit_cnt_nxt[i] = nit_cnt_r[i];
      if (COUNT_CLEAR) begin
        nit_cnt_nxt[i] = `COUNT_RESET;
      end else if (NOT_IN_TABLE_EVT[i] && !nit_full[i]) begin
        nit_cnt_nxt[i] = nit_cnt_r[i] + 8'h01;
      end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
        nit_cnt_r[i] <= `COUNT_RESET;
      end else if (CE) begin
        nit_cnt_r[i] <= nit_cnt_nxt[i];
      end
    end

    // ***********************************************************
    // Unexpected control character counter.
    // ***********************************************************
    // Control character count.
    always_comb begin
      ctrl_cnt_nxt[i] = ctrl_cnt_r[i];
      if (COUNT_CLEAR) begin
        ctrl_cnt_nxt[i] = `COUNT_RESET;
      end else if (UNEXPECTED_CONTROL_EVT[i] && !ctrl_full[i]) begin
        ctrl_cnt_nxt[i] = ctrl_cnt_r[i] + 8'h01;
      end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
        ctrl_cnt_r[i] <= `COUNT_RESET;
      end else if (CE) begin
        ctrl_cnt_r[i] <= ctrl_cnt_nxt[i];
      end
    end

    // ***********************************************************
    // Status byte.
    // ***********************************************************
    // Continuous status capture.
    always_comb begin
      flags_nxt[i] = `FLAGS_RESET;
      flags_nxt[i][`BIT_BAD_DISPARITY] = (disp_cnt_r[i] >= ERROR_LIMIT);
      flags_nxt[i][`BIT_NOT_IN_TABLE] = (nit_cnt_r[i] >= ERROR_LIMIT);
      flags_nxt[i][`BIT_UNEXPECTED_CONTROL] = (ctrl_cnt_r[i] >= ERROR_LIMIT);
      flags_nxt[i][`BIT_DESKEW_OK] = DESKEW_OK[i] && align_valid;
      flags_nxt[i][`BIT_LANE_ALIGN_OK] = LANE_ALIGN_OK[i] && align_valid;
      flags_nxt[i][`BIT_CONFIG_SUM_OK] = CONFIG_SUM_OK[i] && align_valid;
      flags_nxt[i][`BIT_FRAME_ALIGN_OK] = FRAME_ALIGN_OK[i] && align_valid;
      flags_nxt[i][`BIT_CODE_GROUP_LOCK] = CODE_GROUP_LOCK[i];
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
        flags_r[i] <= `FLAGS_RESET;
      end else if (CE) begin
        flags_r[i] <= flags_nxt[i];
      end
    end
  end

  // ***********************************************************
  // Register read port.
  // ***********************************************************
  // Consecutive lane decode.
  assign rd_offset = RD_ADDR - `LANE0_FLAGS_ADDR;
  assign rd_hit = (RD_ADDR >= `LANE0_FLAGS_ADDR) &&
                  (rd_offset < 12'(NUM_LANES));

  // Addresses outside the lane bytes read as a fixed value.
  always_comb begin
    rd_data_nxt = `UNMAPPED_READ;
    for (int k = 0; k < NUM_LANES; k++) begin
      if (rd_hit && rd_offset == 12'(k)) begin
        rd_data_nxt = flags_r[k];
      end
    end
  end

  // ***********************************************************
  // Read answer.
  // ***********************************************************
  // Reads change nothing.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      RD_VALID <= 1'b0;
    end else if (CE) begin
      RD_VALID <= RD_EN;
    end
  end

  // Read data holds its last value until the next taken read.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      RD_DATA <= `UNMAPPED_READ;
    end else if (CE && RD_EN) begin
      RD_DATA <= rd_data_nxt;
    end
  end

endmodule
`default_nettype wire

/* File: src/lane_flags_defines.svh */
// Constants of the lane status byte bank: offsets, bit positions, resets.
// Assumes inclusion by bare name from the package and the design file.
`ifndef LANE_FLAGS_DEFINES_SVH
`define LANE_FLAGS_DEFINES_SVH
`define LANE0_FLAGS_ADDR 12'h4b0
`define LANE1_FLAGS_ADDR 12'h4b1
`define LANE2_FLAGS_ADDR 12'h4b2
`define BIT_BAD_DISPARITY 7
`define BIT_NOT_IN_TABLE 6
`define BIT_UNEXPECTED_CONTROL 5
`define BIT_DESKEW_OK 4
`define BIT_LANE_ALIGN_OK 3
`define BIT_CONFIG_SUM_OK 2
`define BIT_FRAME_ALIGN_OK 1
`define BIT_CODE_GROUP_LOCK 0
`define FLAGS_RESET 8'h00
`define COUNT_RESET 8'h00
`define COUNT_MAX 8'hff
`define UNMAPPED_READ 8'h00
`endif

/* File: src/lane_flags_pkg.sv */
// Types shared by the lane status byte bank.
// Assumes the defines header sits in the include path.
`include "lane_flags_defines.svh"
package lane_flags_pkg;
  typedef logic [7:0] flag_byte_type;
  typedef logic [7:0] error_count_type;
  typedef logic [11:0] reg_addr_type;
endpackage

/* File: sim/lane_flags_monitor.sv */
// Checker of the read port and lane bytes.
// Assumes a bind to the bank, CE high.
`timescale 1ns/1ps
`default_nettype none
module lane_flags_monitor #(parameter int NUM_LANES = 3) (
  input wire logic CLK_SYS, RST_N, CE, COUNT_CLEAR, RD_EN, RD_VALID,
  input wire logic SKIP_ALIGNMENT_SEQUENCE,
  input wire logic [7:0] ERROR_LIMIT, RD_DATA,
  input wire logic [11:0] RD_ADDR,
  input wire logic [NUM_LANES-1:0] CODE_GROUP_LOCK
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  sequence s_rd0; CE && RD_EN && RD_ADDR == 12'h4b0 && $past(RST_N);
  endsequence
  sequence s_clr;
    (COUNT_CLEAR && ERROR_LIMIT != 8'h00 && $stable(ERROR_LIMIT))[*3];
  endsequence
  chk_read_valid: assert property (CE && RD_EN |=> RD_VALID)
    else $error("valid");
  chk_valid_cause: assert property (RD_VALID |-> $past(RD_EN))
    else $error("stray");
  chk_unmapped_zero: assert property (CE && RD_EN &&
    RD_ADDR - 12'h4b0 >= NUM_LANES |=> RD_DATA == 8'h00) else $error("map");
  chk_reset_zero: assert property (!$past(RST_N) |->
    !RD_VALID && RD_DATA == 8'h00) else $error("reset");
  chk_sync_bit: assert property (s_rd0 ##0
    $stable(CODE_GROUP_LOCK[0]) |=> RD_DATA[0] == $past(CODE_GROUP_LOCK[0]))
    else $error("sync");
  chk_skip_void: assert property (s_rd0 ##0
    $stable(SKIP_ALIGNMENT_SEQUENCE) && SKIP_ALIGNMENT_SEQUENCE
    |=> RD_DATA[4:1] == 4'h0) else $error("skip");
  chk_limit_zero: assert property (s_rd0 ##0 ERROR_LIMIT == 8'h00 &&
    $past(ERROR_LIMIT) == 8'h00 |=> RD_DATA[7:5] == 3'h7) else $error("lim");
  chk_clear_flags: assert property (s_clr ##0 s_rd0
    |=> RD_DATA[7:5] == 3'h0) else $error("clear");
endmodule
`default_nettype wire

/* File: sim/lane_tx_model.sv */
// Transmitter model: error bursts on chosen lanes.
// Assumes one burst command per cycle.
`timescale 1ns/1ps
`default_nettype none
module lane_tx_model (
  input wire logic clk,
  input wire logic [2:0] kind, lanes,
  output logic [2:0] bd, nit, uek
);
  always_ff @(posedge clk) begin
    {bd, nit, uek} <= {kind[0] ? lanes : 3'h0, kind[1] ? lanes : 3'h0,
      kind[2] ? lanes : 3'h0};
  end
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Random bench of the lane status bytes.
// Assumes the monitor and transmitter model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench;
  logic clk = 0, rst_n = 0, clr = 0, skip = 0, rd_en = 0, valid, ce = 1;
  logic [2:0] dsk = 0, aln = 0, cks = 0, frm = 0, cgs = 0, kind = 0, ln = 0;
  logic [2:0] bd, nit, uek;
  logic [7:0] lim = 0, data, cnt [3][3];
  logic [11:0] addr = 0;
  int seed = 90, n_errors = 0, checked = 0;
  lane_tx_model u_tx (.clk(clk), .kind(kind), .lanes(ln), .bd(bd),
    .nit(nit), .uek(uek));
  serdes_lane_link_status u_dut (.CLK_SYS(clk), .RST_N(rst_n), .CE(ce),
    .BAD_DISPARITY_EVT(bd), .NOT_IN_TABLE_EVT(nit),
    .UNEXPECTED_CONTROL_EVT(uek), .COUNT_CLEAR(clr), .ERROR_LIMIT(lim),
    .DESKEW_OK(dsk), .LANE_ALIGN_OK(aln), .CONFIG_SUM_OK(cks),
    .FRAME_ALIGN_OK(frm), .CODE_GROUP_LOCK(cgs),
    .SKIP_ALIGNMENT_SEQUENCE(skip), .RD_EN(rd_en), .RD_ADDR(addr),
    .RD_DATA(data), .RD_VALID(valid));
  function automatic logic [7:0] expb(int l);
    if (l > 2) return 8'h00;
    return {cnt[l][0] >= lim, cnt[l][1] >= lim, cnt[l][2] >= lim,
      skip ? 4'h0 : {dsk[l], aln[l], cks[l], frm[l]}, cgs[l]};
  endfunction
  task automatic rd(int l);
    @(posedge clk);
    rd_en <= 1;
    addr <= 12'h4b0 + 12'(l);
    @(posedge clk);
    rd_en <= 0;
    @(negedge clk);
    `CHK("valid", 1'b1, valid)
    `CHK("byte", expb(l), data)
  endtask
  task automatic summarize();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial forever #25 clk = ~clk;
  initial begin
    #200000;
    n_errors++;
    summarize();
  end
  initial begin
    foreach (cnt[l, k]) cnt[l][k] = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    @(negedge clk);
    `CHK("reset", 8'h00, data)
    for (int r = 0; r < 24; r++) begin
      @(posedge clk);
      {dsk, aln, cks, frm, cgs} <= 15'($random(seed));
      {skip, clr, lim} <= r ? 10'($random(seed)) & 10'h303 : 10'h101;
      {kind, ln} <= 6'($random(seed));
      @(posedge clk);
      kind <= 0;
      foreach (cnt[l, k])
        cnt[l][k] = clr ? 8'h00 : cnt[l][k] + 8'(kind[k] & ln[l]);
      repeat (3) @(posedge clk);
      for (int i = 0; i < 8; i++) rd(i % 4);
      @(posedge clk);
      ce <= 0;
      rd_en <= 1;
      addr <= 12'h4b1;
      repeat (2) @(posedge clk);
      ce <= 1;
      rd_en <= 0;
      @(negedge clk);
      `CHK("frozen", 1'b0, valid)
    end
    summarize();
  end
endmodule
bind serdes_lane_link_status lane_flags_monitor #(.NUM_LANES(NUM_LANES))
  u_mon (.*);
`default_nettype wire
